// ===== logic/prv_map.svh
// Register offsets, reset values and field positions of the port reset block.
`ifndef PRV_MAP_SVH
`define PRV_MAP_SVH
`define PRV_OFF_CTRL        12'h000
`define PRV_OFF_IOCR_UPPER  12'h004
`define PRV_OFF_PDR_LOW     12'h008
`define PRV_OFF_PDR_HIGH    12'h00C
`define PRV_OFF_PDISC_DIG   12'h010
`define PRV_OFF_PDISC_P14   12'h014
`define PRV_OFF_PDISC_P15   12'h018
`define PRV_OFF_PORT15_INPUT_VALUE      12'h01C
`define PRV_IOCR_SYS_RST    32'h0000_0000
`define PRV_IOCR_MOD_RST    32'h2020_2020
`define PRV_PDR_SYS_RST     32'h2222_2222
`define PRV_PDR_MOD_RST     32'h0000_0000
`define PRV_PDISC_MOD_RST   32'h0000_0000
`define PRV_PDISC_ANA_SYS   32'hFFFF_FFFF
`define PRV_P15_STUCK_MASK  32'h0000_0030
`define PRV_CTRL_MODRST_BIT 0
`define PRV_ZERO            32'h0000_0000
`endif

// ===== logic/prv_pkg.sv
// Types shared by the port reset block.
`default_nettype none
package prv_pkg;
  typedef logic [31:0] prv_word_t;
  typedef logic [11:0] prv_addr_t;
endpackage : prv_pkg
`default_nettype wire

// ===== logic/prv_port_regs.sv
// Port register set with distinct system and module reset values, APB slave.
`timescale 1ns/100ps
`default_nettype none
`include "prv_map.svh"

module prv_port_regs #(
  parameter logic [31:0] PDISC_DIG_STRAP = 32'h0000_0000
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_b_i,
  input  wire logic             psel_i,
  input  wire logic             penable_i,
  input  wire logic             pwrite_i,
  input  wire prv_pkg::prv_addr_t paddr_i,
  input  wire prv_pkg::prv_word_t pwdata_i,
  input  wire logic [31:0]      p14_pad_i,
  input  wire logic [31:0]      p15_pad_i,
  output logic                  pready_o,
  output logic                  pslverr_o,
  output prv_pkg::prv_word_t    prdata_o,
  output prv_pkg::prv_word_t    pin_control_upper_reg_o,
  output prv_pkg::prv_word_t    pad_driver_reg_low_o,
  output prv_pkg::prv_word_t    pad_driver_reg_high_o,
  output prv_pkg::prv_word_t    p14_digital_in_o,
  output prv_pkg::prv_word_t    port15_input_value_o
);
  import prv_pkg::*;

  prv_word_t pin_control_upper_reg;
  prv_word_t next_pin_control_upper_reg;
  prv_word_t pad_driver_reg_low;
  prv_word_t next_pad_driver_reg_low;
  prv_word_t pad_driver_reg_high;
  prv_word_t next_pad_driver_reg_high;
  prv_word_t pin_digital_disable_reg;
  prv_word_t next_pin_digital_disable_reg;
  prv_word_t p14_digital_disable_reg;
  prv_word_t next_p14_digital_disable_reg;
  prv_word_t port15_digital_disable_reg;
  prv_word_t next_port15_digital_disable_reg;
  prv_word_t p14_sync1;
  prv_word_t next_p14_sync1;
  prv_word_t p14_sync2;
  prv_word_t next_p14_sync2;
  prv_word_t p15_sync1;
  prv_word_t next_p15_sync1;
  prv_word_t p15_sync2;
  prv_word_t next_p15_sync2;
  prv_word_t p14_in;
  prv_word_t next_p14_in;
  prv_word_t port15_input_value;
  prv_word_t next_port15_input_value;
  prv_word_t prdata;
  prv_word_t next_prdata;
  logic      pready;
  logic      next_pready;
  logic      pslverr;
  logic      next_pslverr;
  logic      strap_taken;
  logic      next_strap_taken;
  logic      port_module_reset_request;
  logic      wr_acc;
  logic      rd_acc;
  logic      hit;

  assign wr_acc = psel_i && penable_i && pwrite_i && pready;
  assign rd_acc = psel_i && !penable_i && !pwrite_i;
  // Writing the control bit pulses a module reset; the bit itself is not stored.
  assign port_module_reset_request = wr_acc && paddr_i == `PRV_OFF_CTRL && pwdata_i[`PRV_CTRL_MODRST_BIT];

  // Unmapped offsets answer with an error and have no effect.
  function automatic logic decode_hit(input prv_addr_t a);
    decode_hit = (a == `PRV_OFF_CTRL) ||
                 (a == `PRV_OFF_IOCR_UPPER) ||
                 (a == `PRV_OFF_PDR_LOW) ||
                 (a == `PRV_OFF_PDR_HIGH) ||
                 (a == `PRV_OFF_PDISC_DIG) ||
                 (a == `PRV_OFF_PDISC_P14) ||
                 (a == `PRV_OFF_PDISC_P15) ||
                 (a == `PRV_OFF_PORT15_INPUT_VALUE);
  endfunction : decode_hit

  assign hit = decode_hit(paddr_i);

  always_comb begin
    next_pin_control_upper_reg      = pin_control_upper_reg;
    next_pad_driver_reg_low         = pad_driver_reg_low;
    next_pad_driver_reg_high        = pad_driver_reg_high;
    next_pin_digital_disable_reg    = pin_digital_disable_reg;
    next_p14_digital_disable_reg    = p14_digital_disable_reg;
    next_port15_digital_disable_reg = port15_digital_disable_reg;
    next_strap_taken                = 1'b1;
    // The strap is a port value, so it is caught on the first edge after release, not under reset.
    if (!strap_taken) begin
      next_pin_digital_disable_reg = PDISC_DIG_STRAP;
    end
    if (port_module_reset_request) begin
      // Only the port registers reload; nothing else in the design sees this reset.
      next_pin_control_upper_reg      = `PRV_IOCR_MOD_RST;
      next_pad_driver_reg_low         = `PRV_PDR_MOD_RST;
      next_pad_driver_reg_high        = `PRV_PDR_MOD_RST;
      next_pin_digital_disable_reg    = `PRV_PDISC_MOD_RST;
      next_p14_digital_disable_reg    = `PRV_PDISC_MOD_RST;
      next_port15_digital_disable_reg = `PRV_PDISC_MOD_RST;
    end else if (wr_acc) begin
      case (paddr_i)
        `PRV_OFF_IOCR_UPPER: next_pin_control_upper_reg = pwdata_i;
        `PRV_OFF_PDR_LOW:    next_pad_driver_reg_low = pwdata_i;
        `PRV_OFF_PDR_HIGH:   next_pad_driver_reg_high = pwdata_i;
        `PRV_OFF_PDISC_P14:  next_p14_digital_disable_reg = pwdata_i;
        `PRV_OFF_PDISC_P15:  next_port15_digital_disable_reg = pwdata_i & ~`PRV_P15_STUCK_MASK;
        default: ; // Purely digital disable register and input value are read-only.
      endcase
    end
  end

  // Pads are asynchronous, so two stages settle them before the gating logic looks at them.
  always_comb begin
    next_p14_sync1 = p14_pad_i;
    next_p14_sync2 = p14_sync1;
    next_p15_sync1 = p15_pad_i;
    next_p15_sync2 = p15_sync1;
    // Disable bit set forces the digital input to zero.
    next_p14_in    = p14_sync2 & ~p14_digital_disable_reg;
    // Bits 4 and 5 can never be disabled, so they pass whatever the analog level gives.
    next_port15_input_value    = p15_sync2 & ~port15_digital_disable_reg;
  end

  // Zero wait states: ready and the error flag stand for the one access cycle only.
  always_comb begin
    next_pready  = 1'b0;
    next_pslverr = 1'b0;
    next_prdata  = prdata;
    if (psel_i && !penable_i) begin
      next_pready  = 1'b1;
      next_pslverr = !hit;
    end
    if (rd_acc) begin
      case (paddr_i)
        `PRV_OFF_IOCR_UPPER: next_prdata = pin_control_upper_reg;
        `PRV_OFF_PDR_LOW:    next_prdata = pad_driver_reg_low;
        `PRV_OFF_PDR_HIGH:   next_prdata = pad_driver_reg_high;
        `PRV_OFF_PDISC_DIG:  next_prdata = pin_digital_disable_reg;
        `PRV_OFF_PDISC_P14:  next_prdata = p14_digital_disable_reg;
        `PRV_OFF_PDISC_P15:  next_prdata = port15_digital_disable_reg;
        `PRV_OFF_PORT15_INPUT_VALUE:     next_prdata = port15_input_value;
        default:             next_prdata = `PRV_ZERO;
      endcase
    end
  end

  // The module reset rides the clocked path, so the asynchronous reset tree stays system-only.
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_control_upper_reg      <= `PRV_IOCR_SYS_RST;
      pad_driver_reg_low         <= `PRV_PDR_SYS_RST;
      pad_driver_reg_high        <= `PRV_PDR_SYS_RST;
      pin_digital_disable_reg    <= `PRV_PDISC_MOD_RST;
      p14_digital_disable_reg    <= `PRV_PDISC_ANA_SYS;
      port15_digital_disable_reg <= `PRV_PDISC_ANA_SYS & ~`PRV_P15_STUCK_MASK;
      strap_taken                <= 1'b0;
    end else begin
      pin_control_upper_reg      <= next_pin_control_upper_reg;
      pad_driver_reg_low         <= next_pad_driver_reg_low;
      pad_driver_reg_high        <= next_pad_driver_reg_high;
      pin_digital_disable_reg    <= next_pin_digital_disable_reg;
      p14_digital_disable_reg    <= next_p14_digital_disable_reg;
      port15_digital_disable_reg <= next_port15_digital_disable_reg;
      strap_taken                <= next_strap_taken;
    end
  end

  // Only the second stage is read, so a metastable first stage never reaches the gating.
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      p14_sync1 <= `PRV_ZERO;
      p14_sync2 <= `PRV_ZERO;
      p15_sync1 <= `PRV_ZERO;
      p15_sync2 <= `PRV_ZERO;
      p14_in    <= `PRV_ZERO;
      port15_input_value    <= `PRV_ZERO;
    end else begin
      p14_sync1 <= next_p14_sync1;
      p14_sync2 <= next_p14_sync2;
      p15_sync1 <= next_p15_sync1;
      p15_sync2 <= next_p15_sync2;
      p14_in    <= next_p14_in;
      port15_input_value    <= next_port15_input_value;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prdata  <= `PRV_ZERO;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  assign pready_o                = pready;
  assign pslverr_o               = pslverr;
  assign prdata_o                = prdata;
  assign pin_control_upper_reg_o = pin_control_upper_reg;
  assign pad_driver_reg_low_o    = pad_driver_reg_low;
  assign pad_driver_reg_high_o   = pad_driver_reg_high;
  assign p14_digital_in_o        = p14_in;
  assign port15_input_value_o    = port15_input_value;
endmodule : prv_port_regs
`default_nettype wire

// ===== testbench/prv_port_regs_asserts.sv
// Port-level checks of the port reset block.
`timescale 1ns/100ps
`default_nettype none
module prv_port_regs_asserts
  import prv_pkg::*;
(
  input wire logic      core_clk_i,
  input wire logic      rst_b_i,
  input wire logic      psel_i,
  input wire logic      penable_i,
  input wire logic      pwrite_i,
  input wire prv_addr_t paddr_i,
  input wire prv_word_t pwdata_i,
  input wire logic      pready_o,
  input wire logic      pslverr_o,
  input wire prv_word_t prdata_o,
  input wire prv_word_t pin_control_upper_reg_o,
  input wire prv_word_t pad_driver_reg_low_o,
  input wire prv_word_t pad_driver_reg_high_o,
  input wire logic [31:0] p15_pad_i,
  input wire prv_word_t port15_input_value_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  wire acc = psel_i && penable_i && pready_o;
  wire mr = acc && pwrite_i && paddr_i == 12'h000 && pwdata_i[0];
  // Counts edges since reset so the pad history seen by past values is real.
  logic [1:0] up, next_up;
  always_comb next_up = up + {1'b0, up != 2'd3};
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      up <= '0;
    end else begin
      up <= next_up;
    end
  end
  property p_iocr; mr |=> pin_control_upper_reg_o == 32'h2020_2020; endproperty
  a_iocr: assert property (p_iocr) else $error("bad upper pin control");
  property p_pdr; mr |=> pad_driver_reg_low_o == 32'h0000_0000 && pad_driver_reg_high_o == 32'h0000_0000; endproperty
  a_pdr: assert property (p_pdr) else $error("bad pad driver");
  property p_rdy; psel_i && !penable_i |=> pready_o ##1 !pready_o; endproperty
  a_rdy: assert property (p_rdy) else $error("bad ready");
  property p_err; acc && paddr_i > 12'h01C |-> pslverr_o; endproperty
  a_err: assert property (p_err) else $error("no error");
  property p_keep; acc && pwrite_i && paddr_i > 12'h01C |=> $stable(pin_control_upper_reg_o); endproperty
  a_keep: assert property (p_keep) else $error("stray write");
  property p_p15; up == 2'd3 |-> port15_input_value_o[5:4] == $past(p15_pad_i[5:4], 3); endproperty
  a_p15: assert property (p_p15) else $error("bad pad follow");
  property p_p15rd; acc && !pwrite_i && paddr_i == 12'h018 |-> prdata_o[5:4] == 2'b00; endproperty
  a_p15rd: assert property (p_p15rd) else $error("bits set");
  property p_rd0; acc && !pwrite_i && paddr_i == 12'h000 |-> prdata_o == 32'h0000_0000; endproperty
  a_rd0: assert property (p_rd0) else $error("bad control read");
  c_mr: cover property (mr);
  c_err: cover property (acc && paddr_i > 12'h01C);
  c_p15: cover property (acc && !pwrite_i && paddr_i == 12'h018);
endmodule : prv_port_regs_asserts
`default_nettype wire

// ===== testbench/prv_port_regs_bench.sv
// Self-checking bench for the port reset block.
`timescale 1ns/100ps
`default_nettype none
module prv_port_regs_bench;
  import prv_pkg::*;
  localparam prv_word_t STRAP = 32'h0000_F0F0;
  logic core_clk_i = 0, rst_b_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, pready_o, pslverr_o, err;
  prv_addr_t paddr_i = '0;
  prv_word_t pwdata_i = '0, p14_pad_i = 32'hA5A5_5A5A, p15_pad_i = 32'hFFFF_FFFF;
  prv_word_t prdata_o, iocr, pdrl, pdrh, p14_o, port15_input_value_o, rd;
  int fails = 0, num_checks = 0;
  prv_addr_t ad[6] = '{12'h004, 12'h008, 12'h00C, 12'h010, 12'h014, 12'h018};
  prv_word_t sv[6] = '{32'h0, 32'h2222_2222, 32'h2222_2222, STRAP, 32'hFFFF_FFFF, 32'hFFFF_FFCF};
  prv_word_t mv[6] = '{32'h2020_2020, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
  prv_port_regs #(.PDISC_DIG_STRAP(STRAP)) dut (.core_clk_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .p14_pad_i, .p15_pad_i, .pready_o, .pslverr_o, .prdata_o,
    .pin_control_upper_reg_o(iocr), .pad_driver_reg_low_o(pdrl), .pad_driver_reg_high_o(pdrh),
    .p14_digital_in_o(p14_o), .port15_input_value_o);
  always #2 core_clk_i = ~core_clk_i;
  task automatic chk(input prv_word_t g, input prv_word_t e);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  // One APB transfer; the request is held until ready is seen at an edge.
  task automatic xf(input prv_addr_t a, input logic w, input prv_word_t d);
    int n;
    n = 0;
    @(posedge core_clk_i);
    psel_i <= 1; penable_i <= 0; paddr_i <= a; pwrite_i <= w; pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    // Ready is looked at mid-cycle, where it is settled; the rising edge after it is the one that takes it.
    do begin
      @(negedge core_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    rd  = prdata_o;
    err = pslverr_o;
    @(posedge core_clk_i);
    if (n >= 20) fails++;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask : xf
  task automatic conclude;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude
  initial begin
    repeat (10) @(posedge core_clk_i);
    rst_b_i <= 1;
    repeat (2) @(posedge core_clk_i);
    xf(12'h000, 1, 32'h0);
    for (int i = 0; i < 6; i++) begin xf(ad[i], 0, 0); chk(rd, sv[i]); end
    chk(p14_o, 32'h0);
    chk(port15_input_value_o, 32'h0000_0030);
    xf(12'h010, 1, 32'hFFFF_FFFF); xf(12'h010, 0, 0); chk(rd, STRAP);
    xf(12'h018, 1, 32'hFFFF_FFFF); xf(12'h018, 0, 0); chk(rd, 32'hFFFF_FFCF);
    xf(12'h004, 1, 32'h1234_5678); xf(12'h100, 1, 0); chk(err, 1);
    xf(12'h004, 0, 0); chk(rd, 32'h1234_5678);
    xf(12'h000, 1, 32'h1);
    for (int i = 0; i < 6; i++) begin xf(ad[i], 0, 0); chk(rd, mv[i]); end
    xf(12'h000, 0, 0); chk(rd, 32'h0000_0000);
    chk(p14_o, p14_pad_i);
    xf(12'h004, 1, 32'h1111_0000); xf(12'h004, 0, 0); chk(rd, 32'h1111_0000);
    xf(12'h014, 1, 32'h0000_FFFF); p15_pad_i <= 0; repeat (4) @(posedge core_clk_i);
    chk(p14_o, 32'hA5A5_0000);
    chk(port15_input_value_o, 32'h0);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    for (int i = 0; i < 6; i++) begin xf(ad[i], 0, 0); chk(rd, sv[i]); end
    chk(p14_o, 32'h0);
    conclude();
  end
  initial begin
    #20000;
    fails++;
    conclude();
  end
endmodule : prv_port_regs_bench
bind prv_port_regs prv_port_regs_asserts u_chk (.core_clk_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i,
  .paddr_i, .pwdata_i, .pready_o, .pslverr_o, .prdata_o, .pin_control_upper_reg_o, .pad_driver_reg_low_o,
  .pad_driver_reg_high_o, .p15_pad_i, .port15_input_value_o);
`default_nettype wire
